// ===== common/pbecl_consts.vh
// Purpose: Constants for the I/O bus error classifier and logger
// Assumes: Included once per compilation unit by bare name
// Notes:   Codes are 5 bits; severity is a 2-bit class
`ifndef PBECL_CONSTS_VH
`define PBECL_CONSTS_VH

// ----------------------------------------
// Error codes
// ----------------------------------------
`define PBECL_CODE_NONE      5'h00
`define PBECL_CODE_GNT_IDLE  5'h01
`define PBECL_CODE_SC_ABORT  5'h02
`define PBECL_CODE_SC_MSG    5'h07
`define PBECL_CODE_AGP       5'h11
`define PBECL_CODE_REG_FAULT 5'h12
`define PBECL_CODE_SYS_ERR   5'h1f
`define PBECL_CODE_FATAL_MIN 5'h12

// ----------------------------------------
// Severity classes
// ----------------------------------------
`define PBECL_SEV_NONE  2'h0
`define PBECL_SEV_CORR  2'h1
`define PBECL_SEV_UNC   2'h2
`define PBECL_SEV_FATAL 2'h3

// ----------------------------------------
// Completion message log fields
// ----------------------------------------
`define PBECL_MSG_BYTECNT_BIT 31

// ----------------------------------------
// Grant watchdog, in i_clk_sys clocks
// ----------------------------------------
`define PBECL_GNT_LIMIT_CLKS 5'h0f

`endif

// ===== hdl/pbecl_logger.v
// Purpose: Classify I/O bus error events, capture first error context
// Assumes: Event inputs are one-cycle pulses from logic on i_clk_sys;
//          the system error pin and grant/start pins come from the bus
// Notes:   First error wins; later ones leave the logs and set the overflow flag
`timescale 1ns/100ps
`include "pbecl_consts.vh"

module pbecl_logger #(
  parameter ADDR_W = 64,
  parameter ATTR_W = 36,
  parameter MID_W  = 8,
  parameter MSG_W  = 32,
  parameter DATA_W = 64
) (
  input  wire              i_clk_sys,
  input  wire              i_rstn,
  // Bus pins, asynchronous to the block
  input  wire              i_serr_n,
  input  wire              i_gnt_active,
  input  wire              i_frame_start,
  input  wire [MID_W-1:0]  i_gnt_master,
  // Split completion events
  input  wire              i_dma_sc_abort,
  input  wire              i_sc_reqid_match,
  input  wire              i_sc_tag_match,
  input  wire              i_sc_seq_match,
  input  wire              i_sc_bytecnt_ok,
  input  wire              i_sc_valid,
  input  wire              i_sc_err_msg,
  input  wire              i_sc_msg_handled,
  // Register access and AGP events
  input  wire              i_reg_access,
  input  wire              i_reg_wdata_perr,
  input  wire              i_reg_chain_fault,
  input  wire [ADDR_W-1:0] i_reg_addr,
  input  wire              i_agp_mode,
  input  wire              i_agp_rsvd_cmd,
  input  wire              i_agp_fw_high,
  // Context from slave and master controllers
  input  wire [ADDR_W-1:0] i_slv_addr,
  input  wire [ATTR_W-1:0] i_slv_attr,
  input  wire [MID_W-1:0]  i_slv_master,
  input  wire [MSG_W-1:0]  i_slv_msg,
  input  wire [ADDR_W-1:0] i_mst_addr,
  // Software control
  input  wire              i_hard_fail_select,
  input  wire              i_log_clear,
  input  wire              i_arb_enable_set,
  input  wire              i_arch_clear,
  // Outputs
  output reg  [4:0]        o_error_code,
  output reg  [1:0]        o_error_sev,
  output reg               o_error_valid,
  output reg               o_error_overflow,
  output reg  [ADDR_W-1:0] o_inbound_addr_log,
  output reg  [ATTR_W-1:0] o_inbound_attr_log,
  output reg  [ADDR_W-1:0] o_outbound_addr_log,
  output reg  [MID_W-1:0]  o_offending_master_log,
  output reg  [MSG_W-1:0]  o_completion_message_log,
  output reg               o_arb_enable,
  output reg               o_fatal_mode,
  output reg               o_serr_out,
  output reg               o_sc_claim,
  output reg               o_fake_return,
  output reg               o_fake_hard_fail,
  output reg  [DATA_W-1:0] o_fake_data,
  output reg               o_reg_access_done,
  output reg               o_stat_unexp_sc,
  output reg               o_stat_rcv_sc_err,
  output reg               o_stat_sc_discard
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0]       serr_sync_q;
  reg [1:0]       gnt_sync_q;
  reg [1:0]       start_sync_q;
  reg [MID_W-1:0] mid_sync1_q;
  reg [MID_W-1:0] mid_sync2_q;
  reg [MID_W-1:0] gnt_master_q;
  reg             serr_seen_q;
  reg             gnt_q;

  // Two stages before use; only stage two is read
  // The system error edge is taken from stage two against its own delay
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      serr_sync_q  <= 2'h0;
      gnt_sync_q   <= 2'h0;
      start_sync_q <= 2'h0;
      serr_seen_q  <= 1'b0;
    end else begin
      serr_sync_q  <= {serr_sync_q[0], ~i_serr_n};
      gnt_sync_q   <= {gnt_sync_q[0], i_gnt_active};
      start_sync_q <= {start_sync_q[0], i_frame_start};
      serr_seen_q  <= serr_sync_q[1];
    end
  end

  // Master number rides its own two stages, in step with the grant, so
  // the capture on the synced grant edge never sees a half-settled bus
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      mid_sync1_q  <= {MID_W{1'b0}};
      mid_sync2_q  <= {MID_W{1'b0}};
      gnt_master_q <= {MID_W{1'b0}};
    end else begin
      mid_sync1_q <= i_gnt_master;
      mid_sync2_q <= mid_sync1_q;
      if (gnt_sync_q[1] && !gnt_q)
        gnt_master_q <= mid_sync2_q;
    end
  end

  // ----------------------------------------
  // Grant watchdog
  // ----------------------------------------
  // The count is taken on the synced pins, so it runs two clocks behind
  // the bus; grant and start pass equal stages and stay in step
  reg [4:0] gnt_cnt_q;
  reg       gnt_flagged_q;
  wire      gnt_idle_evt;

  // Counts idle grant clocks; reports once, never drops the grant
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      gnt_q         <= 1'b0;
      gnt_cnt_q     <= 5'h00;
      gnt_flagged_q <= 1'b0;
    end else begin
      gnt_q <= gnt_sync_q[1];
      if (!gnt_sync_q[1] || start_sync_q[1]) begin
        gnt_cnt_q     <= 5'h00;
        gnt_flagged_q <= 1'b0;
      end else if (gnt_cnt_q < `PBECL_GNT_LIMIT_CLKS) begin
        gnt_cnt_q <= gnt_cnt_q + 5'h01;
      end else begin
        gnt_flagged_q <= 1'b1;
      end
    end
  end

  assign gnt_idle_evt = gnt_sync_q[1] && !start_sync_q[1] && !gnt_flagged_q &&
                        (gnt_cnt_q == `PBECL_GNT_LIMIT_CLKS);

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire sc_unmatched = i_sc_valid && i_sc_reqid_match && !i_sc_tag_match;
  // Sequence identity includes the tag, so an unmatched tag never claims
  wire sc_badcount  = i_sc_valid && i_sc_seq_match && i_sc_tag_match &&
                      !i_sc_bytecnt_ok;
  // Byte count error takes precedence over a message on the same completion
  wire sc_msg_evt   = i_sc_valid && i_sc_seq_match && i_sc_bytecnt_ok &&
                      i_sc_err_msg && !i_sc_msg_handled;
  wire reg_fault    = i_reg_access && (i_reg_wdata_perr || i_reg_chain_fault);
  wire agp_evt      = i_agp_mode && (i_agp_rsvd_cmd || i_agp_fw_high);
  wire serr_evt     = serr_sync_q[1] && !serr_seen_q;
  // Both fake-return causes share one response path
  wire fake_evt     = sc_badcount || sc_msg_evt;

  // Priority select of one event per cycle, fatal first
  reg [4:0] ev_code;
  reg [1:0] ev_sev;
  reg       ev_any;
  reg       ld_in, ld_mid, ld_out, ld_msg, ld_regaddr;
  reg [MSG_W-1:0] ev_msg;

  always @* begin
    ev_code    = `PBECL_CODE_NONE;
    ev_sev     = `PBECL_SEV_NONE;
    ev_any     = 1'b1;
    ld_in      = 1'b0;
    ld_mid     = 1'b0;
    ld_out     = 1'b0;
    ld_msg     = 1'b0;
    ld_regaddr = 1'b0;
    ev_msg     = i_slv_msg;
    if (reg_fault) begin
      ev_code    = `PBECL_CODE_REG_FAULT;
      ev_sev     = `PBECL_SEV_FATAL;
      ld_regaddr = 1'b1;
    end else if (serr_evt) begin
      ev_code = `PBECL_CODE_SYS_ERR;
      ev_sev  = `PBECL_SEV_FATAL;
    end else if (agp_evt) begin
      ev_code = `PBECL_CODE_AGP;
      ev_sev  = `PBECL_SEV_FATAL;
    end else if (i_dma_sc_abort) begin
      ev_code = `PBECL_CODE_SC_ABORT;
      ev_sev  = `PBECL_SEV_CORR;
      ld_out  = 1'b1;
      ld_msg  = 1'b1;
    end else if (sc_unmatched) begin
      ev_code = `PBECL_CODE_SC_ABORT;
      ev_sev  = `PBECL_SEV_CORR;
      ld_in   = 1'b1;
      ld_mid  = 1'b1;
      ld_msg  = 1'b1;
    end else if (sc_badcount) begin
      ev_code = `PBECL_CODE_SC_MSG;
      ev_sev  = `PBECL_SEV_UNC;
      ld_in   = 1'b1;
      ld_mid  = 1'b1;
      ld_out  = 1'b1;
      ld_msg  = 1'b1;
      ev_msg  = {MSG_W{1'b0}};
      ev_msg[`PBECL_MSG_BYTECNT_BIT] = 1'b1;
    end else if (sc_msg_evt) begin
      ev_code = `PBECL_CODE_SC_MSG;
      ev_sev  = `PBECL_SEV_UNC;
      ld_out  = 1'b1;
      ld_msg  = 1'b1;
    end else if (gnt_idle_evt) begin
      ev_code = `PBECL_CODE_GNT_IDLE;
      ev_sev  = `PBECL_SEV_CORR;
      ld_mid  = 1'b1;
    end else begin
      ev_any = 1'b0;
    end
  end

  // Fatal class drives fatal mode; codes from 0x12 up are always raised
  // fatal, and the AGP error is fatal below that range, so a code compare
  // alone would leave the bus running after an AGP error
  wire ev_fatal = ev_any && (ev_sev == `PBECL_SEV_FATAL);

  // ----------------------------------------
  // Error status and auxiliary logs
  // ----------------------------------------
  // Same path in PCI and PCI-X mode; only the AGP mode input reaches it, through the AGP event
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_error_code             <= `PBECL_CODE_NONE;
      o_error_sev              <= `PBECL_SEV_NONE;
      o_error_valid            <= 1'b0;
      o_error_overflow         <= 1'b0;
      o_inbound_addr_log       <= {ADDR_W{1'b0}};
      o_inbound_attr_log       <= {ATTR_W{1'b0}};
      o_outbound_addr_log      <= {ADDR_W{1'b0}};
      o_offending_master_log   <= {MID_W{1'b0}};
      o_completion_message_log <= {MSG_W{1'b0}};
    end else if (ev_any && (!o_error_valid || i_log_clear)) begin
      // New event beats a clear in the same cycle
      o_error_code     <= ev_code;
      o_error_sev      <= ev_sev;
      o_error_valid    <= 1'b1;
      o_error_overflow <= 1'b0;
      // Unloaded logs keep stale content, don't-care for this code
      if (ld_in) begin
        o_inbound_addr_log <= i_slv_addr;
        o_inbound_attr_log <= i_slv_attr;
      end
      if (ld_mid)
        o_offending_master_log <= gnt_idle_evt && !sc_unmatched && !sc_badcount ?
                                  gnt_master_q : i_slv_master;
      if (ld_out)
        o_outbound_addr_log <= i_mst_addr;
      if (ld_regaddr)
        o_outbound_addr_log <= i_reg_addr;
      if (ld_msg)
        o_completion_message_log <= ev_msg;
    end else if (ev_any) begin
      o_error_overflow <= 1'b1;
    end else if (i_log_clear) begin
      o_error_valid    <= 1'b0;
      o_error_code     <= `PBECL_CODE_NONE;
      o_error_sev      <= `PBECL_SEV_NONE;
      o_error_overflow <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fatal mode and arbitration enable
  // ----------------------------------------
  // Only software re-enables; fatal entry wins over a set
  // A set in the same cycle as a fatal event is lost; software repeats it
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_arb_enable <= 1'b1;
      o_fatal_mode <= 1'b0;
    end else if (ev_fatal) begin
      o_arb_enable <= 1'b0;
      o_fatal_mode <= 1'b1;
    end else if (i_arb_enable_set) begin
      o_arb_enable <= 1'b1;
      o_fatal_mode <= 1'b0;
    end
  end

  // ----------------------------------------
  // Completion responses and status bits
  // ----------------------------------------
  // One-cycle pulses toward the bus side; status bits are sticky, except the discard bit, held at zero
  always @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_serr_out        <= 1'b0;
      o_sc_claim        <= 1'b0;
      o_fake_return     <= 1'b0;
      o_fake_hard_fail  <= 1'b0;
      o_fake_data       <= {DATA_W{1'b0}};
      o_reg_access_done <= 1'b0;
      o_stat_unexp_sc   <= 1'b0;
      o_stat_rcv_sc_err <= 1'b0;
      o_stat_sc_discard <= 1'b0;
    end else begin
      o_serr_out        <= i_dma_sc_abort;
      // Unmatched tag gets no claim, so no unexpected status either
      o_sc_claim        <= sc_badcount;
      o_fake_return     <= fake_evt;
      o_fake_hard_fail  <= fake_evt && i_hard_fail_select;
      // Hard fail carries no data, so the data word stays zero then
      o_fake_data       <= fake_evt && !i_hard_fail_select ?
                           {DATA_W{1'b1}} : {DATA_W{1'b0}};
      // Access completes even when faulted
      o_reg_access_done <= i_reg_access;
      // Hardware set wins over software clear
      o_stat_unexp_sc   <= sc_badcount || (o_stat_unexp_sc && !i_arch_clear);
      o_stat_rcv_sc_err <= sc_msg_evt || (o_stat_rcv_sc_err && !i_arch_clear);
      o_stat_sc_discard <= 1'b0;
    end
  end

endmodule

// ===== test/pbecl_logger_monitor.sv
// Purpose: Port-level checks on the error classifier and logger
// Assumes: One clock, synchronous active-low reset
// Notes:   Pin-driven events (system error, grant) are judged by the bench
`timescale 1ns/100ps
module pbecl_logger_monitor (
  input wire       i_clk_sys,
  input wire       i_rstn,
  input wire       i_dma_sc_abort,
  input wire       i_reg_access,
  input wire       i_reg_wdata_perr,
  input wire       i_reg_chain_fault,
  input wire       i_agp_rsvd_cmd,
  input wire       i_agp_fw_high,
  input wire       i_sc_valid,
  input wire       i_sc_reqid_match,
  input wire       i_sc_tag_match,
  input wire       i_sc_seq_match,
  input wire       i_sc_bytecnt_ok,
  input wire       i_log_clear,
  input wire [4:0] o_error_code,
  input wire [1:0] o_error_sev,
  input wire       o_error_valid,
  input wire       o_serr_out,
  input wire       o_sc_claim,
  input wire       o_fake_return,
  input wire       o_stat_unexp_sc,
  input wire       o_stat_sc_discard,
  input wire       o_arb_enable,
  input wire       o_fatal_mode,
  input wire       o_reg_access_done
);
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // No register access, no AGP command and log free, so the event must be logged
  wire quiet = !i_reg_access && !i_agp_rsvd_cmd && !i_agp_fw_high && !o_error_valid;
  chk_abort_log: assert property (
    i_dma_sc_abort && quiet |=> o_error_code == 5'h02 && o_error_sev == 2'h1 && o_serr_out)
    else $error("aborted completion not logged with system error");
  chk_discard_zero: assert property (!o_stat_sc_discard)
    else $error("discarded status bit set");
  chk_tag_noclaim: assert property (
    i_sc_valid && !i_sc_tag_match |=> !o_sc_claim)
    else $error("unmatched tag completion claimed");
  chk_badcnt_claim: assert property (
    i_sc_valid && i_sc_reqid_match && i_sc_tag_match && i_sc_seq_match && !i_sc_bytecnt_ok
    && quiet && !i_dma_sc_abort |=> o_sc_claim && o_fake_return && o_stat_unexp_sc)
    else $error("bad byte count completion not claimed and faked");
  chk_fatal_class: assert property (
    o_error_valid && o_error_code >= 5'h12 |-> o_error_sev == 2'h3)
    else $error("high code without fatal class");
  chk_fatal_arb: assert property ($rose(o_fatal_mode) |-> !o_arb_enable)
    else $error("fatal entry left arbitration enabled");
  chk_reg_fault: assert property (
    i_reg_access && (i_reg_wdata_perr || i_reg_chain_fault) && !o_error_valid
    |=> o_error_code == 5'h12 && o_fatal_mode && o_reg_access_done)
    else $error("register fault not fatal or access dropped");
  chk_first_hold: assert property (
    o_error_valid && !i_log_clear |=> o_error_valid && $stable(o_error_code))
    else $error("captured error code not held");
  // Main scenarios reached
  cov_claim: cover property (o_sc_claim);
  cov_serr: cover property (o_serr_out);
  cov_fatal: cover property (o_error_valid && o_error_code == 5'h12);
endmodule
bind pbecl_logger pbecl_logger_monitor pbecl_logger_monitor_i (.*);

// ===== test/pbecl_bus_model.sv
// Purpose: Bus-side card model driving system error and grant pins
// Assumes: Driven from the bench by task calls
// Notes:   Pins change on the falling edge, away from sampling
`timescale 1ns/100ps
module pbecl_bus_model (
  input  wire        i_clk_sys,
  output logic       o_serr_n,
  output logic       o_gnt_active,
  output logic       o_frame_start,
  output logic [7:0] o_gnt_master
);
  // Idle bus: no error, no grant, master number not meaningful
  initial begin
    o_serr_n = 1'b1;
    o_gnt_active = 1'b0;
    o_frame_start = 1'b0;
    o_gnt_master = 8'hff;
  end
  // Card pulls system error for three clocks
  task pulse_serr;
    @(negedge i_clk_sys) o_serr_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    o_serr_n = 1'b1;
  endtask
  // Granted card starts at clock st (0 = broken card, never starts)
  task grant(input logic [7:0] m, input int st);
    @(negedge i_clk_sys) o_gnt_active = 1'b1;
    o_gnt_master = m;
    for (int k = 1; k <= 22; k++) begin
      @(negedge i_clk_sys);
      o_frame_start = (st != 0 && k >= st);
    end
    o_gnt_active = 1'b0;
    o_frame_start = 1'b0;
    o_gnt_master = ~m; // Released lines do not keep the last value
  endtask
endmodule

// ===== test/pbecl_logger_tb_top.sv
// Purpose: Scenario testbench for the error classifier and logger
// Assumes: Default widths; inputs driven on the falling edge
// Notes:   Each scenario resets first, since fatal mode is sticky
`timescale 1ns/100ps
`define NE @(negedge i_clk_sys)
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h exp %h", $time, g, e); end end
module pbecl_logger_tb_top;
  logic        i_clk_sys = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_serr_n, i_gnt_active, i_frame_start, i_dma_sc_abort, i_sc_valid;
  logic        i_sc_reqid_match, i_sc_tag_match, i_sc_seq_match, i_sc_bytecnt_ok;
  logic        i_sc_err_msg, i_sc_msg_handled, i_reg_access, i_reg_wdata_perr;
  logic        i_reg_chain_fault, i_agp_mode, i_agp_rsvd_cmd, i_agp_fw_high;
  logic        i_hard_fail_select, i_log_clear, i_arb_enable_set, i_arch_clear;
  logic [7:0]  i_gnt_master, i_slv_master, o_offending_master_log;
  logic [63:0] i_reg_addr, i_slv_addr, i_mst_addr, o_inbound_addr_log;
  logic [63:0] o_outbound_addr_log, o_fake_data;
  logic [35:0] i_slv_attr, o_inbound_attr_log;
  logic [31:0] i_slv_msg, o_completion_message_log;
  logic [4:0]  o_error_code;
  logic [1:0]  o_error_sev;
  logic        o_error_valid, o_error_overflow, o_arb_enable, o_fatal_mode, o_serr_out;
  logic        o_sc_claim, o_fake_return, o_fake_hard_fail, o_reg_access_done;
  logic        o_stat_unexp_sc, o_stat_rcv_sc_err, o_stat_sc_discard;
  int          failures = 0;
  int          tests_run = 0;
  // 25 MHz clock
  always #20 i_clk_sys = ~i_clk_sys;
  pbecl_logger pbecl_logger_i (.*);
  pbecl_bus_model pbecl_bus_model_i (.i_clk_sys(i_clk_sys), .o_serr_n(i_serr_n),
    .o_gnt_active(i_gnt_active), .o_frame_start(i_frame_start), .o_gnt_master(i_gnt_master));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Drop event pulses, fault qualifiers and log clear; match flags and AGP mode stay
  task clr;
    {i_dma_sc_abort, i_sc_valid, i_sc_err_msg, i_reg_access, i_agp_rsvd_cmd} = '0;
    {i_agp_fw_high, i_log_clear, i_reg_wdata_perr, i_reg_chain_fault} = '0;
  endtask
  task rst;
    `NE i_rstn = 1'b0;
    clr();
    repeat (8) `NE;
    i_rstn = 1'b1;
  endtask
  // Bounded wait for a logged error; running out ends the run
  task wait_valid(input int lim);
    for (int n = 0; o_error_valid !== 1'b1; n++) begin
      if (n == lim) begin
        failures++;
        end_sim();
      end
      `NE;
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task t_abort;
    rst();
    `NE i_dma_sc_abort = 1'b1;
    i_mst_addr = 64'h1234_5678_9abc_def0;
    i_slv_msg = 32'h1357_2468;
    `NE clr();
    `CHK(o_error_code, 5'h02)
    `CHK(o_error_sev, 2'h1)
    `CHK(o_outbound_addr_log, 64'h1234_5678_9abc_def0)
    `CHK(o_completion_message_log, 32'h1357_2468)
    `CHK(o_serr_out, 1'b1)
    `CHK(o_stat_sc_discard, 1'b0)
    `NE {i_agp_mode, i_agp_rsvd_cmd} = 2'b11;
    `NE clr();
    `CHK(o_error_code, 5'h02)
    `CHK(o_fatal_mode, 1'b1)
    `CHK(o_error_overflow, 1'b1)
    `NE i_log_clear = 1'b1;
    `NE clr();
    `CHK(o_error_valid, 1'b0)
  endtask
  // Unmatched tag, then wrong byte count under both fake-return kinds
  task t_split;
    rst();
    `NE {i_sc_valid, i_sc_reqid_match, i_sc_tag_match, i_sc_bytecnt_ok} = 4'b1101;
    {i_slv_master, i_slv_attr, i_slv_msg} = {8'h5a, 36'h9_8765_4321, 32'hcafe_0001};
    i_slv_addr = 64'h0000_00c0_ffee_0010;
    `NE clr();
    `CHK(o_sc_claim, 1'b0)
    `CHK({o_error_code, o_error_sev}, {5'h02, 2'h1})
    `CHK(o_offending_master_log, 8'h5a)
    `CHK(o_inbound_attr_log, 36'h9_8765_4321)
    `CHK(o_inbound_addr_log, 64'h0000_00c0_ffee_0010)
    `CHK(o_completion_message_log, 32'hcafe_0001)
    `CHK(o_stat_unexp_sc, 1'b0)
    for (int k = 0; k < 2; k++) begin
      rst();
      i_hard_fail_select = k[0];
      `NE {i_sc_valid, i_sc_tag_match, i_sc_seq_match, i_sc_bytecnt_ok} = 4'b1110;
      `NE clr();
      `CHK({o_sc_claim, o_fake_return, o_stat_unexp_sc}, 3'b111)
      `CHK(o_fake_hard_fail, k[0])
      if (k == 0) `CHK(o_fake_data, {64{1'b1}})
      `CHK(o_completion_message_log, 32'h8000_0000)
    end
  endtask
  task t_msg;
    rst();
    `NE {i_sc_valid, i_sc_tag_match, i_sc_seq_match, i_sc_bytecnt_ok} = 4'b1111;
    {i_sc_err_msg, i_sc_msg_handled, i_slv_msg} = {2'b10, 32'h0bad_0c0d};
    `NE clr();
    `CHK(o_completion_message_log, 32'h0bad_0c0d)
    `CHK({o_fake_return, o_stat_rcv_sc_err}, 2'b11)
    `CHK({o_error_code, o_error_sev}, {5'h07, 2'h2})
    repeat (2) `NE;
    `CHK(o_stat_rcv_sc_err, 1'b1)
    `NE i_arch_clear = 1'b1;
    `NE i_arch_clear = 1'b0;
    `CHK(o_stat_rcv_sc_err, 1'b0)
  endtask
  // Register faults and bus-fatal events: fatal class, arbitration off
  task t_fatal;
    for (int k = 0; k < 5; k++) begin
      rst();
      i_reg_addr = 64'h0000_0000_fee0_0040 + 64'(k);
      `NE case (k)
        0: {i_reg_access, i_reg_wdata_perr} = 2'b11;
        1: {i_reg_access, i_reg_chain_fault} = 2'b11;
        2: {i_agp_mode, i_agp_rsvd_cmd} = 2'b11;
        3: {i_agp_mode, i_agp_fw_high} = 2'b11;
        default: pbecl_bus_model_i.pulse_serr();
      endcase
      `NE clr();
      wait_valid(6);
      `CHK(o_error_code, (k < 2) ? 5'h12 : (k < 4) ? 5'h11 : 5'h1f)
      `CHK({o_error_sev, o_fatal_mode, o_arb_enable}, 4'b1110)
      if (k < 2) `CHK(o_outbound_addr_log, i_reg_addr)
      if (k < 2) `CHK(o_reg_access_done, 1'b1)
    end
    `NE i_arb_enable_set = 1'b1;
    `NE i_arb_enable_set = 1'b0;
    `CHK({o_fatal_mode, o_arb_enable}, 2'b01)
  endtask
  // Grant never used by a broken card, then one used in time
  task t_grant;
    rst();
    fork
      pbecl_bus_model_i.grant(8'h3c, 0);
      begin
        repeat (15) `NE;
        `CHK(o_error_valid, 1'b0)
        wait_valid(10);
        `CHK({o_error_code, o_error_sev}, {5'h01, 2'h1})
        `CHK(o_offending_master_log, 8'h3c)
        `CHK(o_arb_enable, 1'b1)
      end
    join
    rst();
    pbecl_bus_model_i.grant(8'h11, 10);
    `CHK(o_error_valid, 1'b0)
  endtask
  initial begin
    clr();
    {i_sc_reqid_match, i_sc_tag_match, i_sc_seq_match, i_sc_bytecnt_ok} = '0;
    {i_sc_msg_handled, i_agp_mode, i_hard_fail_select, i_arb_enable_set, i_arch_clear} = '0;
    {i_reg_addr, i_slv_addr, i_mst_addr, i_slv_attr, i_slv_msg, i_slv_master} = '0;
    t_abort();
    t_split();
    t_msg();
    t_fatal();
    t_grant();
    end_sim();
  end
endmodule
